/* core/imu_pkg.sv */
// Shared constants and types for the inertial sensor two-wire target interface
package imu_pkg;

    // Target addresses chosen by the strap levels
    localparam logic [6:0] ACCEL_ADDR_LOW  = 7'h18;
    localparam logic [6:0] ACCEL_ADDR_HIGH = 7'h19;
    localparam logic [6:0] GYRO_ADDR_LOW   = 7'h68;
    localparam logic [6:0] GYRO_ADDR_HIGH  = 7'h69;

    // Read start address before any register address is written
    localparam logic [7:0] READ_PTR_RESET = 8'h00;

    // Pin synchroniser: order {chip_select, gyro_strap, accel_strap, sda, scl}
    localparam int         SYNC_WIDTH = 5;
    localparam logic [4:0] SYNC_INIT  = 5'h1b; // Both lines idle high, no false start
    localparam int         SYNC_SCL   = 0;
    localparam int         SYNC_SDA   = 1;
    localparam int         SYNC_ASTR  = 2;
    localparam int         SYNC_GSTR  = 3;
    localparam int         SYNC_CS    = 4;

    // Cycles after reset release before the straps are trusted
    localparam logic [1:0] STRAP_CAPTURE_CYCLES = 2'h3;

    // Bit counter limits
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST  = 3'h7;

    typedef enum logic {
        PART_ACCEL,
        PART_GYRO
    } imu_part_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_REG,
        ST_REG_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK,
        ST_IGNORE
    } imu_state_t;

    // Bus conditions seen on the synchronised lines
    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } imu_bus_ev_t;

    typedef struct packed {
        logic       valid;
        imu_part_t  part;
        logic [7:0] addr;
        logic [7:0] data;
    } imu_wr_t;

    typedef struct packed {
        logic       valid;
        imu_part_t  part;
        logic [7:0] addr;
    } imu_rd_t;

endpackage

/* core/imu_sync.sv */
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module imu_sync #(
    parameter int                 W    = 1,
    parameter logic [W-1:0]       INIT = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // First stage feeds the second stage only
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_reg <= INIT;
            q        <= INIT;
        end
        else
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule // imu_sync

/* core/imu_cond.sv */
// Start, stop and clock edge detector on the synchronised bus lines
`timescale 1ns/1ps
module imu_cond (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          scl,
    input  wire logic          sda,
    output imu_pkg::imu_bus_ev_t ev
);
    logic scl_prev_reg;
    logic sda_prev_reg;

    // Previous line levels, idle bus is high
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end
        else
        begin
            scl_prev_reg <= scl;
            sda_prev_reg <= sda;
        end
    end

    // Conditions need SCL high on both samples so an edge race is not mistaken
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ev <= '{start: 1'b0, stop: 1'b0, scl_rise: 1'b0, scl_fall: 1'b0, sda: 1'b1};
        end
        else
        begin
            ev.start    <= scl_prev_reg & scl & sda_prev_reg & ~sda;
            ev.stop     <= scl_prev_reg & scl & ~sda_prev_reg & sda;
            ev.scl_rise <= ~scl_prev_reg & scl;
            ev.scl_fall <= scl_prev_reg & ~scl;
            ev.sda      <= sda;
        end
    end
endmodule // imu_cond

/* core/imu_target.sv */
// Two-wire target interface with accelerometer and gyroscope addresses
`timescale 1ns/1ps
module imu_target (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          scl,
    input  wire logic          sda_in,
    output logic               sda_out,
    output logic               sda_oe_n,
    input  wire logic          accel_addr_strap,
    input  wire logic          gyro_addr_strap,
    input  wire logic          accel_chip_select,
    output logic               busy,
    output logic               accel_spi_mode,
    output imu_pkg::imu_wr_t   wr_req,
    output imu_pkg::imu_rd_t   rd_req,
    input  wire logic [7:0]    rd_data
);
    logic [imu_pkg::SYNC_WIDTH-1:0] pins_s;
    imu_pkg::imu_bus_ev_t           ev;
    imu_pkg::imu_state_t            state_reg;
    imu_pkg::imu_part_t             part_reg;
    logic [7:0]                     shift_reg;
    logic [2:0]                     bit_cnt_reg;
    logic [7:0]                     ptr_reg;
    logic [7:0]                     base_addr_reg;
    logic                           ack_half_reg;
    logic                           acked_reg;
    logic                           armed_reg;
    logic [1:0]                     cap_cnt_reg;
    logic                           accel_strap_reg;
    logic                           gyro_strap_reg;
    logic                           cs_prev_reg;
    logic [7:0]                     byte_in;
    logic                           last_bit;
    logic                           hit_accel;
    logic                           hit_gyro;

    // Strap selects the low address bit of one part
    function automatic logic [6:0] target_addr(input logic strap, input logic [6:0] lo,
                                               input logic [6:0] hi);
        target_addr = strap ? hi : lo;
    endfunction

    // All pins cross into the clock domain here
    imu_sync #(
        .W    (imu_pkg::SYNC_WIDTH),
        .INIT (imu_pkg::SYNC_INIT)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({accel_chip_select, gyro_addr_strap, accel_addr_strap, sda_in, scl}),
        .q   (pins_s)
    );

    imu_cond u_cond (
        .clk (clk),
        .rst (rst),
        .scl (pins_s[imu_pkg::SYNC_SCL]),
        .sda (pins_s[imu_pkg::SYNC_SDA]),
        .ev  (ev)
    );

    // Byte completes on the eighth rising clock
    assign byte_in  = {shift_reg[6:0], ev.sda};
    assign last_bit = (bit_cnt_reg == imu_pkg::BIT_LAST);

    // Only a 7-bit address is compared; 10-bit prefixes simply miss
    assign hit_accel = ~accel_spi_mode &
        (byte_in[7:1] == target_addr(accel_strap_reg, imu_pkg::ACCEL_ADDR_LOW,
                                     imu_pkg::ACCEL_ADDR_HIGH));
    assign hit_gyro  = (byte_in[7:1] == target_addr(gyro_strap_reg, imu_pkg::GYRO_ADDR_LOW,
                                                    imu_pkg::GYRO_ADDR_HIGH));

    // Straps are caught once the synchroniser has settled after reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cap_cnt_reg     <= 2'h0;
            accel_strap_reg <= 1'b0;
            gyro_strap_reg  <= 1'b0;
        end
        else if (cap_cnt_reg != imu_pkg::STRAP_CAPTURE_CYCLES)
        begin
            cap_cnt_reg     <= cap_cnt_reg + 2'h1;
            accel_strap_reg <= pins_s[imu_pkg::SYNC_ASTR];
            gyro_strap_reg  <= pins_s[imu_pkg::SYNC_GSTR];
        end
    end

    // Chip-select rise latches SPI mode until the next reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cs_prev_reg    <= 1'b1;
            accel_spi_mode <= 1'b0;
        end
        else
        begin
            cs_prev_reg <= pins_s[imu_pkg::SYNC_CS];
            if (~cs_prev_reg & pins_s[imu_pkg::SYNC_CS])
                accel_spi_mode <= 1'b1;
        end
    end

    // Stop is only honoured after SCL has fallen once since the start
    always_ff @(posedge clk)
    begin
        if (rst)
            armed_reg <= 1'b0;
        else if (ev.start)
            armed_reg <= 1'b0;
        else if (ev.scl_fall)
            armed_reg <= 1'b1;
    end

    // Bus busy from start to an honoured stop
    always_ff @(posedge clk)
    begin
        if (rst)
            busy <= 1'b0;
        else if (ev.start)
            busy <= 1'b1;
        else if (ev.stop && armed_reg)
            busy <= 1'b0;
    end

    // Open-drain pin: data is always low, only the enable moves
    always_ff @(posedge clk)
    begin
        sda_out <= 1'b0;
    end

    // Protocol sequencer; start and stop take priority over clock edges
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg    <= imu_pkg::ST_IDLE;
            part_reg     <= imu_pkg::PART_ACCEL;
            shift_reg    <= 8'h00;
            bit_cnt_reg  <= imu_pkg::BIT_FIRST;
            ptr_reg      <= imu_pkg::READ_PTR_RESET;
            base_addr_reg <= imu_pkg::READ_PTR_RESET;
            ack_half_reg <= 1'b0;
            acked_reg    <= 1'b0;
            sda_oe_n     <= 1'b1;
            wr_req       <= '0;
            rd_req       <= '0;
        end
        else
        begin
            wr_req.valid <= 1'b0;
            rd_req.valid <= 1'b0;
            if (ev.stop && armed_reg)
            begin
                state_reg <= imu_pkg::ST_IDLE;
                sda_oe_n  <= 1'b1;
            end
            else if (ev.start)
            begin
                // Repeated start keeps the register address for the read
                state_reg    <= imu_pkg::ST_ADDR;
                bit_cnt_reg  <= imu_pkg::BIT_FIRST;
                ack_half_reg <= 1'b0;
                sda_oe_n     <= 1'b1;
            end
            else
            begin
                unique case (state_reg)
                    imu_pkg::ST_IDLE, imu_pkg::ST_IGNORE:
                        sda_oe_n <= 1'b1;
                    imu_pkg::ST_ADDR:
                    begin
                        if (ev.scl_rise)
                        begin
                            shift_reg   <= byte_in;
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            if (last_bit)
                            begin
                                if (hit_accel || hit_gyro)
                                begin
                                    state_reg <= imu_pkg::ST_ADDR_ACK;
                                    part_reg  <= imu_pkg::imu_part_t'(~hit_accel);
                                    if (ev.sda)
                                    begin
                                        // Every read restarts at the last written address
                                        rd_req.valid <= 1'b1;
                                        rd_req.addr  <= base_addr_reg;
                                        rd_req.part  <= imu_pkg::imu_part_t'(~hit_accel);
                                        ptr_reg      <= base_addr_reg;
                                    end
                                end
                                else
                                begin
                                    state_reg <= imu_pkg::ST_IGNORE;
                                end
                            end
                        end
                    end
                    imu_pkg::ST_ADDR_ACK, imu_pkg::ST_REG_ACK, imu_pkg::ST_WDATA_ACK:
                    begin
                        // First fall pulls low, second fall releases, or after a read address drives data bit 7
                        if (ev.scl_fall)
                        begin
                            ack_half_reg <= ~ack_half_reg;
                            bit_cnt_reg  <= imu_pkg::BIT_FIRST;
                            if (!ack_half_reg)
                            begin
                                sda_oe_n <= 1'b0;
                            end
                            else if (state_reg == imu_pkg::ST_ADDR_ACK && shift_reg[0])
                            begin
                                state_reg <= imu_pkg::ST_RDATA;
                                shift_reg <= rd_data;
                                sda_oe_n  <= rd_data[7];
                            end
                            else
                            begin
                                sda_oe_n  <= 1'b1;
                                unique case (state_reg)
                                    imu_pkg::ST_ADDR_ACK:  state_reg <= imu_pkg::ST_REG;
                                    imu_pkg::ST_REG_ACK:   state_reg <= imu_pkg::ST_WDATA;
                                    // Only one data byte per write; extras are not acknowledged
                                    default:               state_reg <= imu_pkg::ST_IGNORE;
                                endcase
                            end
                        end
                    end
                    imu_pkg::ST_REG:
                    begin
                        if (ev.scl_rise)
                        begin
                            shift_reg   <= byte_in;
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            if (last_bit)
                            begin
                                base_addr_reg <= byte_in;
                                state_reg <= imu_pkg::ST_REG_ACK;
                            end
                        end
                    end
                    imu_pkg::ST_WDATA:
                    begin
                        if (ev.scl_rise)
                        begin
                            shift_reg   <= byte_in;
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            if (last_bit)
                            begin
                                wr_req.valid <= 1'b1;
                                wr_req.part  <= part_reg;
                                wr_req.addr  <= base_addr_reg;
                                wr_req.data  <= byte_in;
                                state_reg    <= imu_pkg::ST_WDATA_ACK;
                            end
                        end
                    end
                    imu_pkg::ST_RDATA:
                    begin
                        // Data changes only while SCL is low
                        if (ev.scl_fall)
                        begin
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            shift_reg   <= {shift_reg[6:0], 1'b0};
                            if (last_bit)
                            begin
                                sda_oe_n  <= 1'b1;
                                ptr_reg   <= ptr_reg + 8'h01;
                                acked_reg <= 1'b0;
                                state_reg <= imu_pkg::ST_RDATA_ACK;
                            end
                            else
                            begin
                                sda_oe_n <= shift_reg[6];
                            end
                        end
                    end
                    imu_pkg::ST_RDATA_ACK:
                    begin
                        if (ev.scl_rise)
                        begin
                            if (ev.sda)
                            begin
                                state_reg <= imu_pkg::ST_IGNORE;
                            end
                            else
                            begin
                                acked_reg    <= 1'b1;
                                rd_req.valid <= 1'b1;
                                rd_req.addr  <= ptr_reg;
                                rd_req.part  <= part_reg;
                            end
                        end
                        else if (ev.scl_fall && acked_reg)
                        begin
                            state_reg   <= imu_pkg::ST_RDATA;
                            bit_cnt_reg <= imu_pkg::BIT_FIRST;
                            shift_reg   <= rd_data;
                            sda_oe_n    <= rd_data[7];
                        end
                    end
                    default:
                    begin
                        state_reg <= imu_pkg::ST_IDLE;
                        sda_oe_n  <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule // imu_target

/* testbench/imu_target_props.sv */
// Port-level assertions for the two-wire target
`timescale 1ns/1ps
module imu_target_props (
    input wire logic             clk,
    input wire logic             rst,
    input wire logic             scl,
    input wire logic             sda_in,
    input wire logic             sda_out,
    input wire logic             sda_oe_n,
    input wire logic             accel_addr_strap,
    input wire logic             gyro_addr_strap,
    input wire logic             accel_chip_select,
    input wire logic             busy,
    input wire logic             accel_spi_mode,
    input wire imu_pkg::imu_wr_t wr_req,
    input wire imu_pkg::imu_rd_t rd_req,
    input wire logic [7:0]       rd_data
);
    logic       scl_d_reg;
    logic [3:0] fall_age_reg;
    logic       seen_fall_reg;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Pin delay line for clock edge finding
    always_ff @(posedge clk)
        scl_d_reg <= scl;

    // Age of last clock fall; saturates so long idles cannot wrap
    always_ff @(posedge clk)
    begin
        if (rst || (scl_d_reg && !scl))
            fall_age_reg <= 4'h0;
        else if (fall_age_reg != 4'hf)
            fall_age_reg <= fall_age_reg + 4'h1;
    end

    // Clock fell inside this transfer, so a stop counts
    always_ff @(posedge clk)
    begin
        if (rst || !busy)
            seen_fall_reg <= 1'b0;
        else if (scl_d_reg && !scl)
            seen_fall_reg <= 1'b1;
    end

    sequence s_start;
        scl && $fell(sda_in) && !busy;
    endsequence

    sequence s_stop;
        scl && $rose(sda_in) && seen_fall_reg;
    endsequence

    sequence s_bare_stop;
        scl && $rose(sda_in) && busy && !seen_fall_reg;
    endsequence

    AST_OPEN_DRAIN: assert property (!sda_out)
        else $error("data pin driven high");
    AST_ACK_IN_LOW: assert property ($changed(sda_oe_n) |-> fall_age_reg <= 4'h6)
        else $error("data pin changed outside the clock low phase");
    AST_START_BUSY: assert property (s_start |-> ##[1:6] busy)
        else $error("start not followed by busy");
    AST_STOP_IDLE: assert property (s_stop |-> ##[1:6] !busy)
        else $error("stop did not end the transfer");
    AST_BARE_STOP: assert property (s_bare_stop |-> busy [*8])
        else $error("stop right after start was taken");
    AST_IDLE_RELEASED: assert property (!busy |-> sda_oe_n)
        else $error("data pin pulled while idle");
    AST_WR_PULSE: assert property (wr_req.valid |-> busy ##1 !wr_req.valid)
        else $error("write request not a single pulse in a transfer");
    AST_RD_PULSE: assert property (rd_req.valid |-> busy ##1 !rd_req.valid)
        else $error("read request not a single pulse in a transfer");
    AST_SPI_LATCH: assert property ($rose(accel_chip_select) |-> ##[1:6] accel_spi_mode)
        else $error("chip select rise did not latch serial mode");
    AST_SPI_STICKY: assert property (accel_spi_mode |=> accel_spi_mode)
        else $error("serial mode dropped");
endmodule // imu_target_props

bind imu_target imu_target_props u_props (
    .clk(clk), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .accel_addr_strap(accel_addr_strap),
    .gyro_addr_strap(gyro_addr_strap), .accel_chip_select(accel_chip_select),
    .busy(busy), .accel_spi_mode(accel_spi_mode), .wr_req(wr_req),
    .rd_req(rd_req), .rd_data(rd_data)
);

/* testbench/imu_ctl_model.sv */
// Behavioural two-wire bus controller facing the target
`timescale 1ns/1ps
module imu_ctl_model (
    output logic      scl,
    output logic      sda_drv,
    input  wire logic sda
);
    // Idle bus: clock stands high, data released to the pull-up
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // Start or repeated start; long low first so a pending ack ends
    task automatic start();
        sda_drv = 1'b1;
        #500 scl = 1'b1;
        #300 sda_drv = 1'b0;
        #300 scl = 1'b0;
    endtask

    // One clock: low 500 ns, high 300 ns, sampled mid-high
    task automatic bit_io(input logic b, output logic r);
        #200 sda_drv = b;
        #300 scl = 1'b1;
        #150 r = sda;
        #150 scl = 1'b0;
    endtask

    // Byte out MSB first, then data released for the target's ack
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, ack);
    endtask

    // Byte in, then ack for more or refuse on the last
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask

    // Data rises with clock high to end the transfer
    task automatic stop();
        #200 sda_drv = 1'b0;
        #300 scl = 1'b1;
        #300 sda_drv = 1'b1;
        #300;
    endtask

    // Start then stop with no clock pulse between
    task automatic start_stop();
        #300 sda_drv = 1'b0;
        #800 sda_drv = 1'b1;
        #300;
    endtask
endmodule // imu_ctl_model

/* testbench/imu_target_test.sv */
// Self-checking bench for the two-wire target
`timescale 1ns/1ps
module imu_target_test;
    logic             clk = 1'b0;
    logic             rst = 1'b1;
    logic             accel_addr_strap;
    logic             gyro_addr_strap;
    logic             accel_chip_select = 1'b0;
    logic [7:0]       rd_data = 8'h00;
    logic             sda_out;
    logic             sda_oe_n;
    logic             busy;
    logic             accel_spi_mode;
    imu_pkg::imu_wr_t wr_req;
    imu_pkg::imu_rd_t rd_req;
    wire logic        scl;
    wire logic        sda_drv;
    wire logic        sda = sda_drv & (sda_oe_n | sda_out);
    logic [7:0]       mem [256];
    logic [16:0]      wr_q [$];
    logic [7:0]       ptr_base = 8'h00;
    logic             spi_exp = 1'b0;
    int               failures = 0;
    int               checked = 0;
    int unsigned      seed;

    always #50 clk = ~clk;

    imu_target uut (
        .clk               (clk),
        .rst               (rst),
        .scl               (scl),
        .sda_in            (sda),
        .sda_out           (sda_out),
        .sda_oe_n          (sda_oe_n),
        .accel_addr_strap  (accel_addr_strap),
        .gyro_addr_strap   (gyro_addr_strap),
        .accel_chip_select (accel_chip_select),
        .busy              (busy),
        .accel_spi_mode    (accel_spi_mode),
        .wr_req            (wr_req),
        .rd_req            (rd_req),
        .rd_data           (rd_data)
    );

    imu_ctl_model ctl (.scl(scl), .sda_drv(sda_drv), .sda(sda));

    // Register store answers one cycle after each read request
    always @(posedge clk)
    begin
        if (rd_req.valid === 1'b1)
            rd_data <= #1 mem[rd_req.addr];
        if (wr_req.valid === 1'b1)
            wr_q.push_back({wr_req.part, wr_req.addr, wr_req.data});
    end

    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (failures == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    function automatic logic [6:0] acc_a();
        return accel_addr_strap ? imu_pkg::ACCEL_ADDR_HIGH : imu_pkg::ACCEL_ADDR_LOW;
    endfunction

    function automatic logic [6:0] gyr_a();
        return gyro_addr_strap ? imu_pkg::GYRO_ADDR_HIGH : imu_pkg::GYRO_ADDR_LOW;
    endfunction

    // Accel drops off the bus once serial mode is latched
    function automatic logic acked(input logic [6:0] a);
        return (a == acc_a() && !spi_exp) || a == gyr_a();
    endfunction

    // Full register write; the request must carry part, address and data
    task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d);
        logic ack;
        ctl.start();
        ctl.put_byte({a, 1'b0}, ack);
        chk(busy, 1'b1);
        chk(ack, 1'b0);
        ctl.put_byte(r, ack);
        chk(ack, 1'b0);
        ctl.put_byte(d, ack);
        chk(ack, 1'b0);
        ctl.stop();
        #2000;
        ptr_base = r;
        chk(17'(wr_q.size()), 17'h1);
        if (wr_q.size() > 0) chk(wr_q.pop_front(), {a == gyr_a(), r, d});
    endtask

    // Optional address phase, repeated start, then n bytes in sequence
    task automatic rd(input logic [6:0] a, input logic setr, input logic [7:0] r, input int n);
        logic       ack;
        logic [7:0] d;
        if (setr)
        begin
            ctl.start();
            ctl.put_byte({a, 1'b0}, ack);
            ctl.put_byte(r, ack);
            ptr_base = r;
        end
        ctl.start();
        ctl.put_byte({a, 1'b1}, ack);
        chk(ack, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            ctl.get_byte(i == n - 1, d);
            chk(d, mem[8'(ptr_base + i)]);
        end
        ctl.stop();
    endtask

    // Own, neighbouring and foreign addresses
    task automatic probe();
        logic [6:0] t [5];
        logic       ack;
        t = '{acc_a(), acc_a() ^ 7'h01, gyr_a(), gyr_a() ^ 7'h01, 7'h2a};
        foreach (t[i])
        begin
            ctl.start();
            ctl.put_byte({t[i], 1'b0}, ack);
            chk(ack, !acked(t[i]));
            ctl.stop();
        end
    endtask

    // Main sequence
    initial
    begin
        seed = $urandom(59);
        foreach (mem[i]) mem[i] = 8'($urandom());
        accel_addr_strap = 1'($urandom());
        gyro_addr_strap = 1'($urandom());
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        rd(gyr_a(), 1'b0, 8'h00, 2);
        rd(acc_a(), 1'b0, 8'h00, 1);
        wr(acc_a(), 8'($urandom()), 8'($urandom()));
        rd(acc_a(), 1'b1, 8'hfe, 3);
        rd(acc_a(), 1'b0, 8'h00, 2);
        wr(gyr_a(), 8'($urandom()), 8'($urandom()));
        rd(gyr_a(), 1'b0, 8'h00, 2);
        probe();
        ctl.start_stop();
        chk(busy, 1'b1);
        wr(gyr_a(), 8'($urandom()), 8'($urandom()));
        repeat (6) @(posedge clk);
        #1;
        chk(busy, 1'b0);
        accel_chip_select = 1'b1;
        spi_exp = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk(accel_spi_mode, 1'b1);
        probe();
        report_and_stop();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        #3_000_000;
        failures++;
        report_and_stop();
    end
endmodule // imu_target_test
